// File: src/gcc_pkg.sv
// constants for the general-call and configuration-bit command slave
// assumes a single 20 MHz clock and an open-drain bus resolved outside
// Functional notes
// [R01] ack general-call address, decode next byte
// [R02] odd second byte: ignore until stop
// [R03] reset code: abort, reload from nonvolatile
// [R04] no reset delay timer after reset
// [R05] wake-up code clears all power-down selects
// [R06] wake-up leaves nonvolatile copies, no write
// [R07] codes 04h and 00h not acknowledged
// [R08] config-bit commands need high-voltage pin
// [R09] config-bit to nonvolatile address: error, nack
// [R10] write cycle starts only after stop
// [R11] during write only volatile commands accepted
// [R12] write-active flag spans whole write cycle
// [R13] master probes with read bit, then stop
// [R14] software reset touches only bus state; the start in it also clears pend_q
// [R15] invalid command: release data, wait start
// [R16] start or missing ack resets interface
// [R17] after general call return to idle
package gcc_pkg;
  localparam logic [7:0] GC_ADDR      = 8'h00;
  localparam logic [7:0] GC_RESET     = 8'h06;
  localparam logic [7:0] GC_WAKEUP    = 8'h0A;
  localparam logic [7:0] GC_RSVD_A    = 8'h04;
  localparam logic [7:0] GC_RSVD_B    = 8'h00;
  // command byte: address [7:3], opcode [2:1]
  localparam int         CMD_OP_LSB   = 1;
  localparam int         CMD_AD_LSB   = 3;
  // bit counter: last data bit, then the acknowledge slot
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [1:0] OP_WRITE     = 2'h0;
  localparam logic [1:0] OP_CFG_EN    = 2'h1;
  localparam logic [1:0] OP_CFG_DIS   = 2'h2;
  localparam logic [1:0] OP_READ      = 2'h3;
  // addresses at or above this are nonvolatile
  localparam logic [4:0] NV_BASE      = 5'h10;
  localparam logic [4:0] LOCK_ADDR    = 5'h00;
  localparam int         CLK_HZ       = 20000000;
  localparam int         TWC_US       = 10;
  localparam int         TWC_CYC      = (TWC_US * (CLK_HZ / 1000000) > 0) ? TWC_US * (CLK_HZ / 1000000) : 1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b011,
    ST_GC   = 3'b100,
    ST_WAIT = 3'b101
  } gcc_state_t;
endpackage

// File: src/gcc_slave.sv
// i2c slave: general call, high-voltage config-bit commands, write cycle
// assumes scl/sda sampled from pins; open drain resolved by the bench
`timescale 1ns/1ps
module gcc_slave #(
  parameter int         NCH     = 8,
  parameter logic [6:0] DEV_ADR = 7'h60,
  parameter int         TWC     = gcc_pkg::TWC_CYC
) (
  input  wire logic             clk,                          // 20 MHz
  input  wire logic             resetn,                       // sync, active low
  input  wire logic             scl_i,                        // bus clock pin
  input  wire logic             sda_i,                        // bus data pin
  output logic                  sda_oe_n,                     // low pulls sda low
  input  wire logic             high_voltage_command_pin,     // high-voltage level seen
  input  wire logic [2*NCH-1:0] nv_power_down_select,         // nonvolatile copies
  output logic [2*NCH-1:0]      channel_power_down_select,    // volatile selects
  output logic [1:0]            cfg_bits,                     // lock, write protect
  output logic                  nonvolatile_write_active_flag,// write cycle busy
  output logic                  command_error,                // last command faulted
  output logic                  reload_pulse                  // reload from nonvolatile
);
  gcc_pkg::gcc_state_t st_q, st_d;
  logic [2:0] scl_s, sda_s;
  logic       scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic       ack_q, gc_q, hv_s1, hv_s2, hv_s3, hv_q, pend_q, pend_en_q;
  logic [31:0] twc_q;
  wire scl_rise  = ~scl_q & scl_s[2] & scl_s[1];
  wire scl_fall  = scl_q & ~scl_s[2] & ~scl_s[1];
  wire sda_stab  = scl_s[2] == scl_s[1] && sda_s[2] == sda_s[1];
  wire start_c   = sda_stab & scl_q & scl_s[2] & sda_q & ~sda_s[2];
  wire stop_c    = sda_stab & scl_q & scl_s[2] & ~sda_q & sda_s[2];
  wire [7:0] byte_w = {sh_q[6:0], sda_s[2]};
  wire byte_done = scl_rise & (bit_q == gcc_pkg::BIT_LAST);
  wire ack_slot  = bit_q == gcc_pkg::BIT_ACK;
  wire busy      = twc_q != 32'h0;
  wire [1:0] op_w = byte_w[gcc_pkg::CMD_OP_LSB +: 2];
  wire [4:0] ad_w = byte_w[gcc_pkg::CMD_AD_LSB +: 5];
  wire nv_w      = ad_w >= gcc_pkg::NV_BASE;
  wire cfg_cmd   = op_w == gcc_pkg::OP_CFG_EN || op_w == gcc_pkg::OP_CFG_DIS;
  // [R01] address match
  wire adr_gc    = byte_w == gcc_pkg::GC_ADDR;
  wire adr_me    = byte_w[7:1] == DEV_ADR;
  // [R08] hv gate
  wire cfg_ok    = cfg_cmd & hv_q & ~nv_w & ~busy;
  // [R11] busy filter
  wire cmd_ok    = cfg_cmd ? cfg_ok : (~nv_w | ~busy);
  // [R07] only reset and wake-up acknowledged
  wire gc_known  = byte_w == gcc_pkg::GC_RESET || byte_w == gcc_pkg::GC_WAKEUP;
  wire gc_hw     = byte_w[0];
  always_ff @(posedge clk) begin
    scl_s <= {scl_s[1:0], scl_i};
    sda_s <= {sda_s[1:0], sda_i};
    hv_s1 <= high_voltage_command_pin;
    hv_s2 <= hv_s1;
    hv_s3 <= hv_s2;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      hv_q  <= 1'b0;
    end else begin
      if (scl_s[2] == scl_s[1]) scl_q <= scl_s[2];
      if (sda_s[2] == sda_s[1]) sda_q <= sda_s[2];
      if (hv_s3 == hv_s2) hv_q <= hv_s3;
    end
  end
  always_comb begin
    st_d = st_q;
    if (byte_done) begin
      case (st_q)
        gcc_pkg::ST_ADDR: st_d = adr_gc ? gcc_pkg::ST_GC : (adr_me ? gcc_pkg::ST_CMD : gcc_pkg::ST_WAIT);
        // [R02] hardware call
        gcc_pkg::ST_GC:   st_d = gcc_pkg::ST_WAIT;
        // [R09] error nack
        gcc_pkg::ST_CMD:  st_d = cmd_ok ? gcc_pkg::ST_DATA : gcc_pkg::ST_WAIT;
        gcc_pkg::ST_DATA: st_d = gcc_pkg::ST_DATA;
        default:          st_d = st_q;
      endcase
    end
  end
  // [R16] start and missing ack reset interface
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q  <= gcc_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      ack_q <= 1'b0;
      gc_q  <= 1'b0;
    end else if (start_c) begin
      st_q  <= gcc_pkg::ST_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
    // [R17] idle after stop
    end else if (stop_c) begin
      st_q  <= gcc_pkg::ST_IDLE;
      ack_q <= 1'b0;
    end else begin
      if (scl_rise && st_q != gcc_pkg::ST_IDLE) begin
        sh_q  <= byte_w;
        bit_q <= ack_slot ? 4'h0 : bit_q + 4'h1;
        // [R16] nack from master on read data ends
        if (ack_slot && ack_q == 1'b0 && st_q == gcc_pkg::ST_DATA && sda_s[2]) st_q <= gcc_pkg::ST_WAIT;
      end
      if (byte_done) begin
        st_q <= st_d;
        // [R15] invalid byte keeps sda released
        ack_q <= (st_q == gcc_pkg::ST_ADDR && (adr_gc | adr_me))
               | (st_q == gcc_pkg::ST_GC && !gc_hw && gc_known)
               | (st_q == gcc_pkg::ST_CMD && cmd_ok)
               | (st_q == gcc_pkg::ST_DATA);
        gc_q <= st_q == gcc_pkg::ST_GC && !gc_hw && gc_known;
      end
      // [R17] general call done: back to idle
      if (scl_fall && ack_slot) begin
        ack_q <= 1'b0;
        if (gc_q) st_q <= gcc_pkg::ST_IDLE;
        gc_q <= 1'b0;
      end
    end
  end
  // ack drive begins after scl falls so sda never changes with scl high
  always_ff @(posedge clk) begin
    if (!resetn) sda_oe_n <= 1'b1;
    else if (scl_fall) sda_oe_n <= ~(ack_q & ack_slot);
    else if (start_c || stop_c) sda_oe_n <= 1'b1;
  end

  logic [7:0] gc_byte_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gc_byte_q <= 8'h00;
    end else if (byte_done) begin
      gc_byte_q <= byte_w;
    end
  end
  wire gc_act     = scl_fall & ack_slot & gc_q;
  wire do_reset   = gc_act && gc_byte_q == gcc_pkg::GC_RESET;
  wire do_wake    = gc_act && gc_byte_q == gcc_pkg::GC_WAKEUP;
  wire cfg_taken  = byte_done && st_q == gcc_pkg::ST_CMD && cfg_ok;
  // [R10] write only after stop
  wire twc_start  = stop_c & pend_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channel_power_down_select     <= '0;
      cfg_bits                      <= 2'b00;
      pend_q                        <= 1'b0;
      pend_en_q                     <= 1'b0;
      twc_q                         <= 32'd0;
      nonvolatile_write_active_flag <= 1'b0;
      command_error                 <= 1'b0;
      reload_pulse                  <= 1'b0;
    end else begin
      // [R03] reload, [R04] output at once, no delay timer
      reload_pulse <= do_reset;
      if (do_reset) channel_power_down_select <= nv_power_down_select;
      // [R05] wake-up, [R06] nv copies untouched
      else if (do_wake) channel_power_down_select <= '0;
      if (cfg_taken) begin
        pend_q    <= 1'b1;
        // opcode of this command alone decides set or clear
        pend_en_q <= op_w == gcc_pkg::OP_CFG_EN;
      end else if (start_c || twc_start) pend_q <= 1'b0;
      // [R09] error flag
      if (byte_done && st_q == gcc_pkg::ST_CMD) command_error <= ~cmd_ok;
      if (twc_start) begin
        twc_q <= 32'(TWC);
        cfg_bits <= pend_en_q ? 2'b11 : 2'b00;
      end else if (busy) twc_q <= twc_q - 32'h1;
      // [R12] flag spans cycle
      nonvolatile_write_active_flag <= twc_start | (twc_q > 32'h1);
    end
  end
  // [R14] bus reset touches the state machine and clears pend_q; other registers above untouched
  // [R12] busy flag tracks counter
  property p_wa_flag;
    @(posedge clk) disable iff (!resetn) nonvolatile_write_active_flag == busy;
  endproperty
  a_wa_flag: assert property (p_wa_flag) else $error("write flag dropped early"); // [R12]
  property p_wake;
    @(posedge clk) disable iff (!resetn) do_wake |=> channel_power_down_select == '0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up did not clear"); // [R05]
  property p_twc_stop;
    @(posedge clk) disable iff (!resetn) $rose(nonvolatile_write_active_flag) |-> $past(stop_c);
  endproperty
  a_twc_stop: assert property (p_twc_stop) else $error("write began without stop"); // [R10]
  property p_reload;
    @(posedge clk) disable iff (!resetn) do_reset |=> reload_pulse ##1 !reload_pulse;
  endproperty
  a_reload: assert property (p_reload) else $error("reload pulse wrong"); // [R03]
  property p_hv;
    @(posedge clk) disable iff (!resetn)
      (byte_done && st_q == gcc_pkg::ST_CMD && cfg_cmd && !hv_q) |=> !ack_q && command_error;
  endproperty
  a_hv: assert property (p_hv) else $error("config acked without high voltage"); // [R08]
  property p_start;
    @(posedge clk) disable iff (!resetn) start_c |=> st_q == gcc_pkg::ST_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start did not restart"); // [R16]
  property p_nvack;
    @(posedge clk) disable iff (!resetn)
      (byte_done && st_q == gcc_pkg::ST_CMD && cfg_cmd && nv_w) |=> !ack_q && command_error;
  endproperty
  a_nvack: assert property (p_nvack) else $error("nonvolatile config acked"); // [R09]
  property p_hwgc;
    @(posedge clk) disable iff (!resetn)
      (byte_done && st_q == gcc_pkg::ST_GC && gc_hw) |=> st_q == gcc_pkg::ST_WAIT && !ack_q;
  endproperty
  a_hwgc: assert property (p_hwgc) else $error("hardware call acked"); // [R02]

  property p_rsvd;
    @(posedge clk) disable iff (!resetn)
      (byte_done && st_q == gcc_pkg::ST_GC && !gc_known) |=> !ack_q;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unsupported general call acked"); // [R07]
  property p_busy_nv;
    @(posedge clk) disable iff (!resetn)
      (byte_done && st_q == gcc_pkg::ST_CMD && busy && nv_w) |=> !ack_q;
  endproperty
  a_busy_nv: assert property (p_busy_nv) else $error("nonvolatile command acked during write"); // [R11]
  property p_gc_idle;
    @(posedge clk) disable iff (!resetn) gc_act |=> st_q == gcc_pkg::ST_IDLE;
  endproperty
  a_gc_idle: assert property (p_gc_idle) else $error("general call did not return to idle"); // [R17]
endmodule // gcc_slave

// File: dv/gcc_master.sv
// bus master model: drives scl and its share of sda
// assumes sda is wired-and with the device and pulled up
`timescale 1ns/1ps
module gcc_master #(
  parameter int H = 8
) (
  input  wire logic clk,   // bench clock
  input  wire logic sda_i, // resolved sda
  output logic      scl_o, // bus clock
  output logic      sda_o  // low pulls sda low
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hw();
    repeat (H) @(posedge clk);
    #2;
  endtask
  // scl dropped first so sda moves never look like start or stop
  task automatic start();
    scl_o = 1'b0;
    hw();
    sda_o = 1'b1;
    hw();
    scl_o = 1'b1;
    hw();
    sda_o = 1'b0;
    hw();
  endtask
  task automatic stop();
    scl_o = 1'b0;
    hw();
    sda_o = 1'b0;
    hw();
    scl_o = 1'b1;
    hw();
    sda_o = 1'b1;
    hw();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    scl_o = 1'b0;
    hw();
    sda_o = b;
    hw();
    scl_o = 1'b1;
    hw();
    r = sda_i;
  endtask
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], r);
    end
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rst_seq();
    logic r;
    start();
    repeat (9) clk_bit(1'b1, r);
    start();
    stop();
  endtask
endmodule // gcc_master

// File: dv/test_gcc_slave.sv
// self-checking bench for the general-call and config-bit slave
// assumes default channel count of eight; write cycle lengthened to 2000 cycles
`timescale 1ns/1ps
module test_gcc_slave;
  localparam int          TWC = 2000;
  localparam logic [15:0] NV  = 16'hA5C3;
  typedef struct packed {
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic        hv;
    logic        a2;
    logic        rl;
    logic [15:0] sel;
  } gcc_row_t;
  gcc_row_t    rows [7] = '{'{8'h00, 8'h06, 1'b0, 1'b1, 1'b1, NV}, '{8'h00, 8'h04, 1'b0, 1'b0, 1'b0, NV},
                            '{8'h00, 8'h00, 1'b0, 1'b0, 1'b0, NV}, '{8'h00, 8'h07, 1'b0, 1'b0, 1'b0, NV},
                            '{8'h00, 8'h0A, 1'b0, 1'b1, 1'b0, 16'h0000}, '{8'hC0, 8'h02, 1'b0, 1'b0, 1'b0, 16'h0000},
                            '{8'hC0, 8'h82, 1'b1, 1'b0, 1'b0, 16'h0000}};
  logic        clk, resetn, hv, scl, sda_m, oe_n, wr_flag, cerr, rl, ack;
  logic [15:0] sel;
  logic [1:0]  cfg;
  wire         sda = sda_m & oe_n;
  int          errors, comparisons, cyc, rl_cnt, wr_len, n0;
  gcc_slave #(.TWC(TWC)) dut (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_oe_n(oe_n),
    .high_voltage_command_pin(hv), .nv_power_down_select(NV), .channel_power_down_select(sel),
    .cfg_bits(cfg), .nonvolatile_write_active_flag(wr_flag), .command_error(cerr), .reload_pulse(rl));
  gcc_master u_m (.clk(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    rl_cnt += int'(rl === 1'b1);
    wr_len += int'(wr_flag === 1'b1);
    // limit well above the longest sequence
    if (cyc == 60000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic exp);
    u_m.start();
    u_m.xfer(8'hC0, ack);
    u_m.xfer(c, ack);
    chk(ack, exp);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 4000 && wr_flag !== 1'b0; i++) @(posedge clk);
    #2;
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    hv = 1'b0;
    repeat (4) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk({oe_n, sel, cfg, wr_flag, rl, cerr}, {1'b1, 21'h0});
    foreach (rows[k]) begin
      hv = rows[k].hv;
      n0 = rl_cnt;
      u_m.start();
      u_m.xfer(rows[k].b0, ack);
      chk(ack, 1'b1);
      u_m.xfer(rows[k].b1, ack);
      chk(ack, rows[k].a2);
      chk(sel, rows[k].sel);
      u_m.stop();
      chk(rl_cnt - n0, rows[k].rl);
      chk(wr_flag, 1'b0);
    end
    chk(cerr, 1'b1);
    n0 = rl_cnt;
    u_m.start();
    u_m.xfer(8'h00, ack);
    u_m.xfer(8'h07, ack);
    u_m.xfer(8'h06, ack);
    chk(ack, 1'b0);
    u_m.stop();
    chk(rl_cnt - n0, 0);
    cmd(8'h02, 1'b1);
    chk(cerr, 1'b0);
    chk(wr_flag, 1'b0);
    n0 = wr_len;
    u_m.stop();
    cmd(8'h80, 1'b0);
    chk(cerr, 1'b1);
    u_m.stop();
    cmd(8'h08, 1'b1);
    u_m.stop();
    wait_idle();
    chk((wr_len - n0 >= TWC) && (wr_len - n0 <= TWC + 2), 1'b1);
    chk(cfg, 2'h3);
    u_m.start();
    u_m.xfer(8'hC1, ack);
    chk(ack, 1'b1);
    u_m.stop();
    // bus reset cuts into a transfer the device has just acked
    u_m.start();
    u_m.xfer(8'hC0, ack);
    chk(ack, 1'b1);
    u_m.rst_seq();
    chk(cfg, 2'h3);
    u_m.start();
    u_m.xfer(8'h00, ack);
    u_m.xfer(8'h0A, ack);
    chk(ack, 1'b1);
    u_m.stop();
    cmd(8'h04, 1'b1);
    u_m.stop();
    wait_idle();
    chk(cfg, 2'h0);
    close_out();
  end
endmodule // test_gcc_slave
